/* include/cms_regs.vh */
// Register map, field layout and encodings of the channel mode selector.
// Assumes an APB slave with 32-bit data and word-aligned byte addresses.
`ifndef CMS_REGS_VH
`define CMS_REGS_VH

// Byte offsets.
`define CMS_CTRL_OFF        12'h000
`define CMS_EECFG_OFF       12'h004
`define CMS_CMD_OFF         12'h008
`define CMS_STATUS_OFF      12'h00C
`define CMS_CHB_OFF         12'h010

// Control register fields.
`define CMS_CTRL_LOAD_BIT   0
`define CMS_CTRL_ENUM_BIT   1

// Command register fields: value in [7:0], channel in bit 8.
`define CMS_CMD_CH_BIT      8

// Bit-mode command values.
`define CMS_BM_RESET        8'h00
`define CMS_BM_ASYNC_BB     8'h01
`define CMS_BM_SYNC_BB      8'h04
`define CMS_BM_ENGINE       8'h02
`define CMS_BM_HOSTBUS      8'h08
`define CMS_BM_SYNC_FIFO    8'h40

// Base modes held in the configuration word, two bits per channel.
`define CMS_BASE_UART       2'h0
`define CMS_BASE_FIFO       2'h1
`define CMS_BASE_CPU        2'h2
`define CMS_BASE_FSER       2'h3

// Effective channel modes.
`define CMS_MODE_UART       4'h0
`define CMS_MODE_AFIFO      4'h1
`define CMS_MODE_CPU        4'h2
`define CMS_MODE_FSER       4'h3
`define CMS_MODE_ABB        4'h4
`define CMS_MODE_SBB        4'h5
`define CMS_MODE_ENGINE     4'h6
`define CMS_MODE_HOSTBUS    4'h7
`define CMS_MODE_SFIFO      4'h8
`define CMS_MODE_OFF        4'h9

`endif

/* verilog/cms_channel_mode_selector.v */
// Channel mode selector: holds the interface mode of two channels.
// Assumes software on APB writes the configuration word read from the
// EEPROM and forwards host bit-mode commands after enumeration.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "cms_regs.vh"

// Contract
// - Reset leaves both channels in asynchronous serial mode first.
// - After reset the EEPROM configuration is loaded to set each base mode.
// - A base mode is serial, parallel FIFO, processor FIFO or fast serial.
// - After enumeration a bit-mode command selects bit-bang or command engine mode.
// - In parallel FIFO mode the value 0x40 selects synchronous FIFO.
// - Synchronous FIFO gives channel A channel B's memory and disables channel B.
// - An unused channel B keeps default pins: data released, flags idle, strobes in. A disabled B releases data only if it never drove a pin.
// - EEPROM-only modes come only from configuration; host-only modes only by command.
module cms_channel_mode_selector (
	// Clock and reset.
	input  wire        clock,
	input  wire        rst_b,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Channel modes and memory ownership.
	output wire [3:0]  mode_a,
	output wire [3:0]  mode_b,
	output wire        merge_mem,
	output wire        chb_enable,
	// Channel B default pin state.
	output wire [7:0]  chb_data_oe,
	output wire        tx_space_flag_n,
	output wire        rx_avail_flag_n,
	output wire        chb_strobe_oe
);

	////////////////////////////////////////////////////////////////////////
	reg [3:0]  mode_a_ff, mode_b_ff, nxt_mode_a, nxt_mode_b;
	reg [1:0]  base_a_ff, base_b_ff;
	reg        loaded_ff, enum_ff, chb_used_ff, cmd_err_ff;
	reg [7:0]  chb_oe_ff;
	reg [31:0] prdata_ff;
	reg        pready_ff, pslverr_ff;
	reg        nxt_err;

	wire access  = psel & penable & ~pready_ff;
	wire wr      = access & pwrite;
	wire rd      = access & ~pwrite;
	wire mapped  = (paddr == `CMS_CTRL_OFF) | (paddr == `CMS_EECFG_OFF) |
		(paddr == `CMS_CMD_OFF) | (paddr == `CMS_STATUS_OFF) |
		(paddr == `CMS_CHB_OFF);
	wire wr_cmd  = wr & (paddr == `CMS_CMD_OFF);
	wire cmd_ch  = pwdata[`CMS_CMD_CH_BIT];
	wire [7:0] cmd_val = pwdata[7:0];

	// Base mode to effective mode.
	function [3:0] base_mode;
		input [1:0] b;
		begin
			case (b)
				`CMS_BASE_UART: base_mode = `CMS_MODE_UART;
				`CMS_BASE_FIFO: base_mode = `CMS_MODE_AFIFO;
				`CMS_BASE_CPU:  base_mode = `CMS_MODE_CPU;
				default:        base_mode = `CMS_MODE_FSER;
			endcase
		end
	endfunction

	// Command applied to one channel; returns the mode or keeps the old one.
	function [4:0] apply_cmd;
		input [3:0] cur;
		input [1:0] base;
		input [7:0] v;
		begin
			apply_cmd = {1'b1, cur};
			case (v)
				`CMS_BM_RESET:     apply_cmd = {1'b0, base_mode(base)};
				`CMS_BM_ASYNC_BB:  apply_cmd = {1'b0, `CMS_MODE_ABB};
				`CMS_BM_SYNC_BB:   apply_cmd = {1'b0, `CMS_MODE_SBB};
				`CMS_BM_ENGINE:    apply_cmd = {1'b0, `CMS_MODE_ENGINE};
				`CMS_BM_HOSTBUS:   apply_cmd = {1'b0, `CMS_MODE_HOSTBUS};
				`CMS_BM_SYNC_FIFO: begin
					if (base == `CMS_BASE_FIFO)
						apply_cmd = {1'b0, `CMS_MODE_SFIFO};
				end
				default:           apply_cmd = {1'b1, cur};
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Mode selection. Synchronous FIFO is only honoured on channel A with
	// both channels configured as asynchronous FIFO, since it takes B's memory.
	reg [4:0] res;
	always @* begin
		nxt_mode_a = mode_a_ff;
		nxt_mode_b = mode_b_ff;
		nxt_err    = 1'b0;
		res        = 5'h00;
		if (wr && paddr == `CMS_CTRL_OFF && pwdata[`CMS_CTRL_LOAD_BIT]) begin
			nxt_mode_a = base_mode(pwdata[1+8:8]);
			nxt_mode_b = base_mode(pwdata[3+8:10]);
		end else if (wr_cmd) begin
			if (!enum_ff || !loaded_ff) begin
				nxt_err = 1'b1;
			end else if (!cmd_ch) begin
				res = apply_cmd(mode_a_ff, base_a_ff, cmd_val);
				if (cmd_val == `CMS_BM_SYNC_FIFO && base_b_ff != `CMS_BASE_FIFO)
					res = {1'b1, mode_a_ff};
				nxt_err    = res[4];
				nxt_mode_a = res[3:0];
				if (res[3:0] == `CMS_MODE_SFIFO)
					nxt_mode_b = `CMS_MODE_OFF;
				else if (mode_a_ff == `CMS_MODE_SFIFO)
					nxt_mode_b = base_mode(base_b_ff);
			end else if (mode_b_ff == `CMS_MODE_OFF ||
				cmd_val == `CMS_BM_SYNC_FIFO) begin
				nxt_err = 1'b1;
			end else begin
				res = apply_cmd(mode_b_ff, base_b_ff, cmd_val);
				nxt_err    = res[4];
				nxt_mode_b = res[3:0];
			end
		end
	end

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_a_ff   <= `CMS_MODE_UART;
			mode_b_ff   <= `CMS_MODE_UART;
			base_a_ff   <= `CMS_BASE_UART;
			base_b_ff   <= `CMS_BASE_UART;
			loaded_ff   <= 1'b0;
			enum_ff     <= 1'b0;
			chb_used_ff <= 1'b0;
			cmd_err_ff  <= 1'b0;
			chb_oe_ff   <= 8'h00;
		end else begin
			mode_a_ff <= nxt_mode_a;
			mode_b_ff <= nxt_mode_b;
			if (wr && paddr == `CMS_CTRL_OFF) begin
				if (pwdata[`CMS_CTRL_LOAD_BIT]) begin
					base_a_ff <= pwdata[9:8];
					base_b_ff <= pwdata[11:10];
					loaded_ff <= 1'b1;
				end
				enum_ff <= pwdata[`CMS_CTRL_ENUM_BIT];
			end
			if (wr_cmd)
				cmd_err_ff <= nxt_err;
			// Channel B counts as used once it drives any pin.
			if (wr && paddr == `CMS_CHB_OFF) begin
				chb_oe_ff   <= pwdata[7:0];
				chb_used_ff <= chb_used_ff | (|pwdata[7:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB: pready rises one cycle into the access phase (one wait state);
	// unmapped addresses answer with an error and have no effect.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h00000000;
		end else begin
			pready_ff  <= access;
			pslverr_ff <= access & ~mapped;
			if (rd) begin
				case (paddr)
					`CMS_CTRL_OFF:   prdata_ff <= {30'h0, enum_ff, loaded_ff};
					`CMS_EECFG_OFF:  prdata_ff <= {28'h0, base_b_ff, base_a_ff};
					`CMS_CMD_OFF:    prdata_ff <= {31'h0, cmd_err_ff};
					`CMS_STATUS_OFF: prdata_ff <= {23'h0, chb_used_ff, mode_b_ff, mode_a_ff};
					`CMS_CHB_OFF:    prdata_ff <= {24'h0, chb_oe_ff};
					default:         prdata_ff <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Disabled channel B shows default pins; drivers are released only if
	// B never drove a pin, otherwise its last pin setup is left in place.
	// The handshake flags and strobe directions are held at their idle
	// levels, since the FIFO engine that would move them lives outside.
	wire      nxt_off = (nxt_mode_b == `CMS_MODE_OFF);
	reg [7:0] pin_oe_ff;
	reg       merge_ff;
	reg       chb_en_ff;
	reg       tx_flag_n_ff;
	reg       rx_flag_n_ff;
	reg       strobe_oe_ff;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pin_oe_ff    <= 8'h00;
			merge_ff     <= 1'b0;
			chb_en_ff    <= 1'b1;
			tx_flag_n_ff <= 1'b0;
			rx_flag_n_ff <= 1'b1;
			strobe_oe_ff <= 1'b0;
		end else begin
			merge_ff     <= nxt_off;
			chb_en_ff    <= ~nxt_off;
			tx_flag_n_ff <= 1'b0;
			rx_flag_n_ff <= 1'b1;
			strobe_oe_ff <= 1'b0;
			if (nxt_off && !chb_used_ff)
				pin_oe_ff <= 8'h00;
			else
				pin_oe_ff <= (wr && paddr == `CMS_CHB_OFF) ? pwdata[7:0] : chb_oe_ff;
		end
	end

	assign prdata          = prdata_ff;
	assign pready          = pready_ff;
	assign pslverr         = pslverr_ff;
	assign mode_a          = mode_a_ff;
	assign mode_b          = mode_b_ff;
	assign merge_mem       = merge_ff;
	assign chb_enable      = chb_en_ff;
	assign chb_data_oe     = pin_oe_ff;
	assign tx_space_flag_n = tx_flag_n_ff;
	assign rx_avail_flag_n = rx_flag_n_ff;
	assign chb_strobe_oe   = strobe_oe_ff;

endmodule // cms_channel_mode_selector

/* bench/cms_properties.sv */
// Checker for the channel mode selector, watching only its top ports.
// Assumes the bind below attaches it to every selector instance.
`timescale 1ns/1ps
`include "cms_regs.vh"
module cms_checker (
	// Clock and reset.
	input logic        clock,
	input logic        rst_b,
	// APB.
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic        pready,
	input logic        pslverr,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	// Channel modes and channel B pins.
	input logic [3:0]  mode_a,
	input logic [3:0]  mode_b,
	input logic [7:0]  chb_data_oe,
	input logic        merge_mem,
	input logic        chb_enable,
	input logic        tx_space_flag_n,
	input logic        rx_avail_flag_n,
	input logic        chb_strobe_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	AST_RST_UART: assert property (disable iff (1'b0) !rst_b |-> {mode_a, mode_b} == 8'h00)
		else $error("modes not serial during reset");
	AST_ANSWER: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_HOLD: assert property (mode_a != $past(mode_a) || mode_b != $past(mode_b) |-> pready)
		else $error("mode changed without a transfer");
	AST_HOST_ONLY: assert property ($changed(mode_a) && mode_a inside {[4:8]} |->
		$past(paddr) == `CMS_CMD_OFF && $past(pwrite)) else $error("host mode without command");
	AST_SFIFO: assert property ($changed(mode_a) && mode_a == `CMS_MODE_SFIFO |->
		$past(pwdata[8:0]) == 9'h040 && mode_b == `CMS_MODE_OFF) else $error("bad sync fifo entry");
	AST_MERGE: assert property ($changed(mode_b) && mode_b == `CMS_MODE_OFF |-> merge_mem)
		else $error("memory not merged");
	AST_CHB_EN: assert property (chb_enable == !merge_mem)
		else $error("channel B enable wrong");
	AST_PINS: assert property (!tx_space_flag_n && rx_avail_flag_n && !chb_strobe_oe)
		else $error("channel B default pins wrong");
	AST_MERGE_OFF: assert property (merge_mem == (mode_b == `CMS_MODE_OFF))
		else $error("memory merge does not follow channel B off");
	AST_SFIFO_PAIR: assert property ((mode_a == `CMS_MODE_SFIFO) == (mode_b == `CMS_MODE_OFF))
		else $error("channel B off without sync fifo on A");
	AST_HOST_ONLY_B: assert property ($changed(mode_b) && mode_b inside {[4:7]} |->
		$past(paddr) == `CMS_CMD_OFF && $past(pwrite) && $past(pwdata[8]))
		else $error("host mode on B without command");
endmodule // cms_checker

bind cms_channel_mode_selector cms_checker cms_checker_inst (.clock, .rst_b, .psel, .penable,
	.pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .mode_a, .mode_b, .chb_data_oe,
	.merge_mem, .chb_enable, .tx_space_flag_n, .rx_avail_flag_n, .chb_strobe_oe);

/* bench/cms_eeprom_model.sv */
// Configuration memory model: supplies the word read after reset.
// Assumes the bench hands this word to the control register load.
`timescale 1ns/1ps
module cms_eeprom_model #(parameter [1:0] BASE_A = 2'h1, parameter [1:0] BASE_B = 2'h1) (
	output logic [31:0] cfg_word
);
	// Both bases are parallel FIFO so that sync FIFO may be requested later.
	assign cfg_word = {20'h0, BASE_B, BASE_A, 8'h03};
endmodule // cms_eeprom_model

/* bench/channel_mode_selector_tb_top.sv */
// Self-checking bench for the channel mode selector.
// Assumes the design, checker and configuration model are compiled first.
`timescale 1ns/1ps
`include "cms_regs.vh"
module channel_mode_selector_tb_top;
	logic        clock, rst_b, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire  [31:0] prdata, cfg;
	wire  [3:0]  mode_a, mode_b;
	wire  [7:0]  chb_data_oe;
	wire         pready, pslverr, merge_mem, chb_enable, tx_space_flag_n, rx_avail_flag_n, chb_strobe_oe;
	integer      bad_count = 0;
	integer      tests_run = 0;
	cms_channel_mode_selector cms_channel_mode_selector_inst (.clock, .rst_b, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_a, .mode_b, .merge_mem,
		.chb_enable, .chb_data_oe, .tx_space_flag_n, .rx_avail_flag_n, .chb_strobe_oe);
	cms_eeprom_model cms_eeprom_model_inst (.cfg_word(cfg));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		tests_run++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask
	task mchk(input logic [3:0] a, input logic [3:0] b, input string nm);
		chk({24'h0, mode_b, mode_a}, {24'h0, b, a}, nm);
	endtask
	// Held until pready is seen at an edge; only the watchdog ends a hung wait.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_reset_load;
		mchk(`CMS_MODE_UART, `CMS_MODE_UART, "reset modes");
		apb(1'b1, `CMS_CMD_OFF, 32'h1);
		mchk(`CMS_MODE_UART, `CMS_MODE_UART, "early command");
		apb(1'b0, `CMS_CMD_OFF, 32'h0);
		chk(rd, 32'h1, "early command error");
		apb(1'b1, `CMS_CTRL_OFF, cfg);
		mchk(`CMS_MODE_AFIFO, `CMS_MODE_AFIFO, "loaded bases");
		apb(1'b0, `CMS_EECFG_OFF, 32'h0);
		chk(rd, {28'h0, `CMS_BASE_FIFO, `CMS_BASE_FIFO}, "eeprom bases");
		apb(1'b0, `CMS_CTRL_OFF, 32'h0);
		chk(rd, 32'h3, "enumerated and loaded");
		$display("t_reset_load done");
	endtask
	task t_cmds;
		logic [7:0] v [4];
		logic [3:0] m [4];
		v = '{`CMS_BM_ASYNC_BB, `CMS_BM_SYNC_BB, `CMS_BM_ENGINE, `CMS_BM_HOSTBUS};
		m = '{`CMS_MODE_ABB, `CMS_MODE_SBB, `CMS_MODE_ENGINE, `CMS_MODE_HOSTBUS};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `CMS_CMD_OFF, {24'h0, v[i]});
			mchk(m[i], (i == 0) ? `CMS_MODE_AFIFO : m[i - 1], "bit mode A");
			apb(1'b1, `CMS_CMD_OFF, {23'h0, 1'b1, v[i]});
			mchk(m[i], m[i], "bit mode B");
		end
		apb(1'b1, `CMS_CMD_OFF, 32'h3);
		mchk(`CMS_MODE_HOSTBUS, `CMS_MODE_HOSTBUS, "invalid value held");
		apb(1'b0, `CMS_CMD_OFF, 32'h0);
		chk(rd, 32'h1, "invalid value error");
		apb(1'b1, `CMS_CMD_OFF, 32'h0);
		apb(1'b1, `CMS_CMD_OFF, 32'h100);
		mchk(`CMS_MODE_AFIFO, `CMS_MODE_AFIFO, "back to base");
		apb(1'b0, `CMS_STATUS_OFF, 32'h0);
		chk(rd, {23'h0, 1'b0, `CMS_MODE_AFIFO, `CMS_MODE_AFIFO}, "status bases");
		$display("t_cmds done");
	endtask
	task t_sfifo;
		apb(1'b1, `CMS_CTRL_OFF, cfg & 32'hFFFFF3FF);
		apb(1'b1, `CMS_CMD_OFF, 32'h40);
		mchk(`CMS_MODE_AFIFO, `CMS_MODE_UART, "sync fifo needs B fifo");
		apb(1'b1, `CMS_CTRL_OFF, cfg);
		apb(1'b1, `CMS_CMD_OFF, 32'h140);
		mchk(`CMS_MODE_AFIFO, `CMS_MODE_AFIFO, "sync fifo on B");
		apb(1'b1, `CMS_CMD_OFF, 32'h40);
		mchk(`CMS_MODE_SFIFO, `CMS_MODE_OFF, "sync fifo on A");
		chk({22'h0, merge_mem, chb_enable, chb_data_oe}, 32'h200, "merge");
		chk({29'h0, tx_space_flag_n, rx_avail_flag_n, chb_strobe_oe}, 32'h2, "B pins");
		apb(1'b1, `CMS_CMD_OFF, 32'h101);
		mchk(`CMS_MODE_SFIFO, `CMS_MODE_OFF, "B while off");
		apb(1'b0, 12'h0FC, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped");
		apb(1'b1, `CMS_CMD_OFF, 32'h0);
		mchk(`CMS_MODE_AFIFO, `CMS_MODE_AFIFO, "leave sync fifo");
		$display("t_sfifo done");
	endtask
	task t_pins;
		apb(1'b1, `CMS_CHB_OFF, 32'h0F);
		chk({24'h0, chb_data_oe}, 32'h0F, "B drives");
		apb(1'b1, `CMS_CHB_OFF, 32'h00);
		apb(1'b1, `CMS_CMD_OFF, 32'h40);
		chk({24'h0, chb_data_oe}, 32'h00, "B inputs first");
		apb(1'b1, `CMS_CMD_OFF, 32'h0);
		apb(1'b1, `CMS_CHB_OFF, 32'h3C);
		apb(1'b1, `CMS_CMD_OFF, 32'h40);
		chk({24'h0, chb_data_oe}, 32'h3C, "used B keeps pins");
		apb(1'b0, `CMS_STATUS_OFF, 32'h0);
		chk(rd, {23'h0, 1'b1, `CMS_MODE_OFF, `CMS_MODE_SFIFO}, "status merged");
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		mchk(`CMS_MODE_UART, `CMS_MODE_UART, "mid-run reset modes");
		chk({22'h0, merge_mem, chb_enable, chb_data_oe}, 32'h100, "mid-run reset B");
		rst_b <= 1'b1;
		@(posedge clock);
		apb(1'b1, `CMS_CMD_OFF, 32'h40);
		mchk(`CMS_MODE_UART, `CMS_MODE_UART, "command before reload");
		apb(1'b1, `CMS_CTRL_OFF, cfg);
		mchk(`CMS_MODE_AFIFO, `CMS_MODE_AFIFO, "reload after reset");
		$display("t_pins done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset_load;
		t_cmds;
		t_sfifo;
		t_pins;
		final_report;
	end
	// About thirty-five transfers of four cycles each; the limit leaves ample margin.
	initial begin
		#20000;
		bad_count++;
		final_report;
	end
endmodule // channel_mode_selector_tb_top
